// >>> hdl/wdcfg_top.sv
// wdcfg_top: latches the device configuration word, decodes the watchdog
// and clock switching policy, runs the watchdog timer, register port.
// assumes config_word_in is stable from reset release onward.
//
// Local design decisions: strobed register access and the address map.
`timescale 1ns/1ps
module wdcfg_top #(
  parameter int unsigned BASE_TICK_CYC = wdcfg_pkg::BASE_TICK_CYC
) (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic [31:0] config_word_in,
  input wire wdcfg_pkg::wdcfg_bus_req_t bus_in,
  output logic [31:0] rd_data_out,
  output logic cfg_valid_out,
  output logic wdt_running_out,
  output logic wdt_reset_out,
  output logic clk_switch_en_out,
  output logic fail_safe_mon_en_out
);
  import wdcfg_pkg::*;

  typedef enum logic [1:0] {
    WDCFG_LOAD = 2'b00,
    WDCFG_HOLD = 2'b01
  } wdcfg_state_t;

  wdcfg_state_t state;
  logic [31:0] cfg_word;
  wdcfg_set_t set;
  wdcfg_set_t next_set;
  logic sw_en;
  logic running;
  logic timeout_flag;
  logic [BASE_CNT_W-1:0] base_cnt;
  logic [POST_CNT_W-1:0] post_cnt;
  logic [POST_CNT_W-1:0] post_limit;
  logic tick;
  logic expire;
  logic service;
  logic [31:0] next_rd;

  // decode of the raw word, used only at the load step
  always_comb begin
    next_set.force_on = config_word_in[FORCE_ON_BIT];
    // out-of-range codes fall back to the longest period
    if (config_word_in[PS_MSB:PS_LSB] > PS_MAX) begin
      next_set.post_sel = PS_MAX;
    end else begin
      next_set.post_sel = config_word_in[PS_MSB:PS_LSB];
    end
    case (config_word_in[CSM_MSB:CSM_LSB])
      2'b00: begin
        next_set.switch_en = 1'b1;
        next_set.monitor_en = 1'b1;
      end
      2'b01: begin
        next_set.switch_en = 1'b1;
        next_set.monitor_en = 1'b0;
      end
      default: begin
        next_set.switch_en = 1'b0;
        next_set.monitor_en = 1'b0;
      end
    endcase
  end

  // capture one clock after release; async reset may only load constants
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state <= WDCFG_LOAD;
      cfg_word <= RESET_WORD;
      set <= '0;
    end else begin
      case (state)
        WDCFG_LOAD: begin
          cfg_word <= config_word_in;
          set <= next_set;
          state <= WDCFG_HOLD;
        end
        WDCFG_HOLD: begin
          state <= WDCFG_HOLD;
        end
        default: begin
          state <= WDCFG_LOAD;
        end
      endcase
    end
  end

  assign service = bus_in.wr && bus_in.addr == REG_SERVICE && bus_in.wdata[SERVICE_BIT];

  // software enable; a clear is ignored while the force-on bit holds it
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sw_en <= 1'b0;
    end else if (bus_in.wr && bus_in.addr == REG_CTRL) begin
      sw_en <= bus_in.wdata[CTRL_SW_EN_BIT] | set.force_on;
    end
  end

  assign running = state == WDCFG_HOLD && (set.force_on || sw_en);

  assign tick = base_cnt == BASE_CNT_W'(BASE_TICK_CYC - 1);
  assign post_limit = POST_CNT_W'((22'h1 << set.post_sel) - 22'h1);
  assign expire = running && tick && post_cnt == post_limit;

  // base tick prescaler; service restarts the whole period
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      base_cnt <= '0;
    end else if (!running || service || tick) begin
      base_cnt <= '0;
    end else begin
      base_cnt <= base_cnt + BASE_CNT_W'(1);
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      post_cnt <= '0;
    end else if (!running || service || expire) begin
      post_cnt <= '0;
    end else if (tick) begin
      post_cnt <= post_cnt + POST_CNT_W'(1);
    end
  end

  // sticky timeout; a new expiry wins over a clear in the same cycle
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      timeout_flag <= 1'b0;
    end else if (expire) begin
      timeout_flag <= 1'b1;
    end else if (bus_in.wr && bus_in.addr == REG_STATUS && bus_in.wdata[ST_TIMEOUT_BIT]) begin
      timeout_flag <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wdt_reset_out <= 1'b0;
      wdt_running_out <= 1'b0;
      cfg_valid_out <= 1'b0;
      clk_switch_en_out <= 1'b0;
      fail_safe_mon_en_out <= 1'b0;
    end else begin
      wdt_reset_out <= expire;
      wdt_running_out <= running;
      cfg_valid_out <= state == WDCFG_HOLD;
      clk_switch_en_out <= state == WDCFG_HOLD && set.switch_en;
      fail_safe_mon_en_out <= state == WDCFG_HOLD && set.monitor_en;
    end
  end

  // read mux; config word is read-only, writes to it are dropped
  always_comb begin
    next_rd = '0;
    case (bus_in.addr)
      REG_CONFIG: next_rd = cfg_word;
      REG_CTRL: next_rd[CTRL_SW_EN_BIT] = sw_en | set.force_on;
      REG_STATUS: begin
        next_rd[ST_RUN_BIT] = running;
        next_rd[ST_FORCE_BIT] = set.force_on;
        next_rd[ST_SWITCH_BIT] = set.switch_en;
        next_rd[ST_MON_BIT] = set.monitor_en;
        next_rd[ST_TIMEOUT_BIT] = timeout_flag;
        // flags a word whose reserved bits were all programmed to one
        next_rd[ST_RSVD_OK_BIT] = (cfg_word & RSVD_MASK) == RSVD_MASK;
        next_rd[ST_PS_LSB +: 5] = set.post_sel;
      end
      default: next_rd = '0;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rd_data_out <= '0;
    end else if (bus_in.rd) begin
      rd_data_out <= next_rd;
    end else begin
      rd_data_out <= '0;
    end
  end

  // checks
  sequence s_ctrl_clear;
    bus_in.wr && bus_in.addr == REG_CTRL && !bus_in.wdata[CTRL_SW_EN_BIT];
  endsequence

  sequence s_ctrl_read;
    bus_in.rd && bus_in.addr == REG_CTRL;
  endsequence

  sequence s_loaded;
    state == WDCFG_LOAD ##1 state == WDCFG_HOLD;
  endsequence

  a_force_keeps_run: assert property (
    @(posedge core_clk_in) disable iff (!resetn_in)
    (set.force_on && state == WDCFG_HOLD) ##0 s_ctrl_clear |=> ##1 wdt_running_out)
    else $error("watchdog stopped while forced on");

  a_off_at_start: assert property (
    @(posedge core_clk_in) disable iff (!resetn_in)
    s_loaded ##0 !set.force_on && !sw_en |=> !wdt_running_out)
    else $error("watchdog running without force or software enable");

  a_sw_enable: assert property (
    @(posedge core_clk_in) disable iff (!resetn_in)
    state == WDCFG_HOLD && bus_in.wr && bus_in.addr == REG_CTRL
      && bus_in.wdata[CTRL_SW_EN_BIT] |=> ##1 wdt_running_out)
    else $error("software enable did not start watchdog");

  a_post_expire: assert property (
    @(posedge core_clk_in) disable iff (!resetn_in)
    wdt_reset_out |-> $past(post_cnt) == $past(post_limit) && $past(tick))
    else $error("watchdog expired at wrong postscale count");

  a_post_clamp: assert property (
    @(posedge core_clk_in) disable iff (!resetn_in)
    s_loaded ##0 $past(config_word_in[PS_MSB:PS_LSB]) > PS_MAX |-> set.post_sel == PS_MAX)
    else $error("out-of-range postscale not clamped");

  a_csm_off: assert property (
    @(posedge core_clk_in) disable iff (!resetn_in)
    cfg_valid_out && cfg_word[CSM_MSB] |-> !clk_switch_en_out && !fail_safe_mon_en_out)
    else $error("clock switching or monitor on with upper select bit set");

  a_csm_switch: assert property (
    @(posedge core_clk_in) disable iff (!resetn_in)
    cfg_valid_out && cfg_word[CSM_MSB:CSM_LSB] == 2'b01
      |-> clk_switch_en_out && !fail_safe_mon_en_out)
    else $error("select 01 decoded wrongly");

  a_csm_monitor: assert property (
    @(posedge core_clk_in) disable iff (!resetn_in)
    cfg_valid_out && cfg_word[CSM_MSB:CSM_LSB] == 2'b00
      |-> clk_switch_en_out && fail_safe_mon_en_out)
    else $error("select 00 decoded wrongly");

  a_word_held: assert property (
    @(posedge core_clk_in) disable iff (!resetn_in)
    cfg_valid_out |=> $stable(cfg_word) && $stable(set) && cfg_valid_out)
    else $error("latched configuration changed before reset");

  a_load_once: assert property (
    @(posedge core_clk_in) disable iff (!resetn_in)
    s_loaded |-> cfg_word == $past(config_word_in))
    else $error("configuration word not captured at load");

  // reads made during the load step see the reset word, so these wait for hold
  a_force_ctrl_read: assert property (
    @(posedge core_clk_in) disable iff (!resetn_in)
    (state == WDCFG_HOLD && set.force_on) ##0 s_ctrl_read |=> rd_data_out[CTRL_SW_EN_BIT])
    else $error("software enable reads clear while forced on");

  a_sw_stop: assert property (
    @(posedge core_clk_in) disable iff (!resetn_in)
    (state == WDCFG_HOLD && !set.force_on) ##0 s_ctrl_clear |=> ##1 !wdt_running_out)
    else $error("software clear did not stop unforced watchdog");

  a_post_restart: assert property (
    @(posedge core_clk_in) disable iff (!resetn_in)
    wdt_reset_out |-> post_cnt == '0 && base_cnt == '0)
    else $error("counters not restarted after expiry");

  a_quiet_before_load: assert property (
    @(posedge core_clk_in) disable iff (!resetn_in)
    !cfg_valid_out |-> !clk_switch_en_out && !fail_safe_mon_en_out && !wdt_running_out)
    else $error("policy output active before word latched");

  a_config_read: assert property (
    @(posedge core_clk_in) disable iff (!resetn_in)
    state == WDCFG_HOLD && bus_in.rd && bus_in.addr == REG_CONFIG
      |=> rd_data_out == cfg_word)
    else $error("config readback differs from latched word");

  a_run_follows: assert property (
    @(posedge core_clk_in) disable iff (!resetn_in)
    cfg_valid_out && set.force_on |-> wdt_running_out)
    else $error("forced watchdog not running after load");

  a_switch_status: assert property (
    @(posedge core_clk_in) disable iff (!resetn_in)
    state == WDCFG_HOLD && bus_in.rd && bus_in.addr == REG_STATUS
      |=> rd_data_out[ST_SWITCH_BIT] == clk_switch_en_out
      && rd_data_out[ST_MON_BIT] == fail_safe_mon_en_out)
    else $error("status clock bits differ from clock outputs");

  a_clamp_held: assert property (
    @(posedge core_clk_in) disable iff (!resetn_in)
    cfg_valid_out |-> set.post_sel <= PS_MAX)
    else $error("effective postscale above largest code");

endmodule // wdcfg_top

// >>> inc/wdcfg_pkg.sv
// wdcfg_pkg: constants and carriers for the config word / watchdog block
// assumes one 50 MHz clock and a nonvolatile word valid at reset release
package wdcfg_pkg;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned BASE_TICK_US = 1000;
  localparam int unsigned BASE_TICK_CYC = BASE_TICK_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned BASE_CNT_W = 16;
  localparam int unsigned POST_CNT_W = 21;
  // register byte addresses
  localparam logic [3:0] REG_CONFIG = 4'h0;
  localparam logic [3:0] REG_CTRL = 4'h4;
  localparam logic [3:0] REG_SERVICE = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'hC;
  // configuration word fields
  localparam int unsigned FORCE_ON_BIT = 23;
  localparam int unsigned PS_LSB = 16;
  localparam int unsigned PS_MSB = 20;
  localparam int unsigned CSM_LSB = 14;
  localparam int unsigned CSM_MSB = 15;
  localparam logic [4:0] PS_MAX = 5'h14;
  localparam logic [31:0] RSVD_MASK = 32'hFF60_0000;
  // control / status fields
  localparam int unsigned CTRL_SW_EN_BIT = 0;
  localparam int unsigned SERVICE_BIT = 0;
  localparam int unsigned ST_RUN_BIT = 0;
  localparam int unsigned ST_FORCE_BIT = 1;
  localparam int unsigned ST_SWITCH_BIT = 2;
  localparam int unsigned ST_MON_BIT = 3;
  localparam int unsigned ST_TIMEOUT_BIT = 4;
  localparam int unsigned ST_RSVD_OK_BIT = 5;
  localparam int unsigned ST_PS_LSB = 8;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } wdcfg_bus_req_t;

  typedef struct packed {
    logic force_on;
    logic [4:0] post_sel;
    logic switch_en;
    logic monitor_en;
  } wdcfg_set_t;
endpackage

// >>> bench/testbench.sv
// testbench: table-driven checks of config word decode, watchdog control, register port
// assumes wdcfg_top compiled with wdcfg_pkg and a shortened base tick
`timescale 1ns/1ps
module testbench;
  import wdcfg_pkg::*;
  // short base tick keeps watchdog periods to a few cycles
  localparam int unsigned TICK = 4;
  logic core_clk_in = 1'h0;
  logic resetn_in = 1'h0;
  logic [31:0] config_word_in = 32'h0000_0000;
  wdcfg_bus_req_t bus_in = '0;
  logic [31:0] rd_data_out;
  logic cfg_valid_out;
  logic wdt_running_out;
  logic wdt_reset_out;
  logic clk_switch_en_out;
  logic fail_safe_mon_en_out;
  int err_count = 0;
  int check_count = 0;
  int cycles = 0;
  logic [31:0] rdv;
  // config word beside expected status (timeout bit masked out)
  logic [31:0] rows [5][2] = '{'{32'hFFE0_0000, 32'h0000_002F}, '{32'hFF74_4000, 32'h0000_1424},
    '{32'hFF7F_8000, 32'h0000_1420}, '{32'h00E3_C000, 32'h0000_0303},
    '{32'hFFF3_0000, 32'h0000_132F}};

  wdcfg_top #(.BASE_TICK_CYC(TICK)) dut (
    .core_clk_in(core_clk_in),
    .resetn_in(resetn_in),
    .config_word_in(config_word_in),
    .bus_in(bus_in),
    .rd_data_out(rd_data_out),
    .cfg_valid_out(cfg_valid_out),
    .wdt_running_out(wdt_running_out),
    .wdt_reset_out(wdt_reset_out),
    .clk_switch_en_out(clk_switch_en_out),
    .fail_safe_mon_en_out(fail_safe_mon_en_out)
  );

  always #10 core_clk_in = ~core_clk_in;

  always @(posedge core_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      final_report();
    end
  end

  task automatic final_report();
    if (err_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic do_reset(input logic [31:0] w);
    @(posedge core_clk_in);
    resetn_in <= 1'h0;
    config_word_in <= w;
    repeat (5) @(posedge core_clk_in);
    #1;
    chk({cfg_valid_out, wdt_running_out, clk_switch_en_out, fail_safe_mon_en_out}, 0);
    @(posedge core_clk_in);
    resetn_in <= 1'h1;
    repeat (3) @(posedge core_clk_in);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk_in);
    bus_in.addr <= a;
    bus_in.wdata <= d;
    bus_in.wr <= 1'h1;
    @(posedge core_clk_in);
    bus_in.wr <= 1'h0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge core_clk_in);
    bus_in.addr <= a;
    bus_in.rd <= 1'h1;
    @(posedge core_clk_in);
    bus_in.rd <= 1'h0;
    #1;
    rdv = rd_data_out;
  endtask

  // pulse to pulse spacing avoids guessing the start alignment
  task automatic period(input int exp);
    int n;
    n = 0;
    while (wdt_reset_out !== 1'h1 && n < 5000) begin
      @(posedge core_clk_in);
      #1;
      n++;
    end
    n = 0;
    do begin
      @(posedge core_clk_in);
      #1;
      n++;
    end while (wdt_reset_out !== 1'h1 && n < 5000);
    chk(n, exp);
  endtask

  initial begin
    for (int i = 0; i < 5; i++) begin
      do_reset(rows[i][0]);
      chk({cfg_valid_out, wdt_running_out, clk_switch_en_out, fail_safe_mon_en_out},
          {28'h0, 1'h1, rows[i][1][0], rows[i][1][2], rows[i][1][3]});
      rd(REG_STATUS);
      chk(rdv & 32'h0000_1F2F, rows[i][1]);
      rd(REG_CONFIG);
      chk(rdv, rows[i][0]);
    end
    do_reset(32'hFFE0_0000);
    wr(REG_CTRL, 32'h0000_0000);
    repeat (2) @(posedge core_clk_in);
    #1;
    chk(wdt_running_out, 1);
    rd(REG_CTRL);
    chk(rdv, 32'h0000_0001);
    period(TICK);
    do_reset(32'hFFE3_0000);
    period(8 * TICK);
    // steady service every 26 cycles holds off the 32-cycle expiry
    repeat (4) begin
      wr(REG_SERVICE, 32'h0000_0001);
      repeat (24) begin
        @(posedge core_clk_in);
        #1;
        chk(wdt_reset_out, 0);
      end
    end
    wr(REG_SERVICE, 32'h0000_0001);
    rd(REG_STATUS);
    chk(rdv[ST_TIMEOUT_BIT], 1);
    wr(REG_STATUS, 32'h0000_0010);
    rd(REG_STATUS);
    chk(rdv[ST_TIMEOUT_BIT], 0);
    // clear lands in the expiry cycle; the new expiry must win
    period(8 * TICK);
    repeat (30) @(posedge core_clk_in);
    wr(REG_STATUS, 32'h0000_0010);
    #1;
    chk(wdt_reset_out, 1);
    rd(REG_STATUS);
    chk(rdv[ST_TIMEOUT_BIT], 1);
    do_reset(32'hFF60_0000);
    repeat (20) @(posedge core_clk_in);
    #1;
    chk(wdt_running_out, 0);
    wr(REG_CTRL, 32'h0000_0001);
    repeat (2) @(posedge core_clk_in);
    #1;
    chk(wdt_running_out, 1);
    period(TICK);
    wr(REG_CTRL, 32'h0000_0000);
    repeat (2) @(posedge core_clk_in);
    #1;
    chk(wdt_running_out, 0);
    // a late change of the word and a write to it must both be ignored
    @(posedge core_clk_in);
    config_word_in <= 32'hFFFF_FFFF;
    wr(REG_CONFIG, 32'h0000_0000);
    rd(REG_CONFIG);
    chk(rdv, 32'hFF60_0000);
    chk({clk_switch_en_out, fail_safe_mon_en_out}, 2'h3);
    rd(4'h2);
    chk(rdv, 32'h0000_0000);
    final_report();
  end
endmodule // testbench
